/* psc_core.sv */
// Parameter store command handler: frames in, replies out, parameter RAMs and NV port.
// Assumes rx bytes from same-clock logic and an NV memory with a request/done handshake.
`timescale 1ns/1ns

module psc_core (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        standalone_mode,
  input  wire logic        user_auto_restore,
  input  wire logic [7:0]  module_addr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        tx_ready,
  output logic             nv_req,
  output logic             nv_write,
  output logic             nv_global,
  output logic [7:0]       nv_bank,
  output logic [7:0]       nv_index,
  output logic [31:0]      nv_wdata,
  input  wire logic        nv_done,
  input  wire logic [31:0] nv_rdata,
  output logic [31:0]      accumulator,
  output logic             ready
);
  logic [31:0] axis_mem [0:255];
  logic [31:0] glob_mem [0:3][0:255];

  psc_pkg::psc_state_t state_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  frame_reg [0:7];
  logic [7:0]  sum_reg;
  logic [7:0]  status_reg;
  logic [31:0] rval_reg;
  logic [31:0] acc_reg;
  logic        boot_user_reg;
  logic        boot_glob_reg;
  logic [7:0]  boot_idx_reg;
  logic        nv_req_reg;
  logic        nv_write_reg;
  logic        nv_global_reg;
  logic [7:0]  nv_bank_reg;
  logic [7:0]  nv_index_reg;
  logic [31:0] nv_wdata_reg;
  logic        reply_now_reg;
  logic [7:0]  tx_byte_reg;

  function automatic logic bank_ok(input logic [7:0] b);
    bank_ok = (b == psc_pkg::BANK_SETTINGS) || (b == psc_pkg::BANK_USER) || (b == psc_pkg::BANK_IRQ);
  endfunction

  // Running checksum, restarted by the first byte of a frame or reply
  function automatic logic [7:0] sum_step(input logic [3:0] idx, input logic [7:0] acc, input logic [7:0] b);
    if (idx == 4'h0) begin
      sum_step = b;
    end else begin
      sum_step = acc + b;
    end
  endfunction

  // Commands that must wait on the NV port, in either mode
  function automatic logic needs_nv(input logic [7:0] op, input logic [7:0] b);
    unique case (op)
      psc_pkg::OP_SAVE_AXIS, psc_pkg::OP_RELOAD_AXIS: needs_nv = 1'b1;
      psc_pkg::OP_WRITE_GLOBAL: needs_nv = (b == psc_pkg::BANK_SETTINGS);
      psc_pkg::OP_SAVE_GLOBAL: needs_nv = (b == psc_pkg::BANK_USER);
      default: needs_nv = 1'b0;
    endcase
  endfunction

  // Frame fields as received, byte 0 is the target address
  wire [7:0]  op_w     = frame_reg[1];
  wire [7:0]  type_w   = frame_reg[2];
  wire [7:0]  bank_w   = frame_reg[3];
  wire [31:0] value_w  = {frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7]};
  wire        sum_ok_w = (rx_byte == sum_reg);
  wire        for_me_w = (frame_reg[0] == module_addr);
  wire [1:0]  bidx_w   = bank_w[1:0];
  wire        step_w   = clk_en;
  wire        rx_take  = step_w && rx_valid && (state_reg == psc_pkg::PSC_IDLE || state_reg == psc_pkg::PSC_RECV);
  wire        tx_take  = step_w && tx_valid && tx_ready;
  wire [7:0]  sum_next = sum_step(cnt_reg, sum_reg, rx_byte);
  wire [31:0] glob_rd_w = glob_mem[bidx_w][type_w];

  // Only a frame that is ours and passed its checksum may change anything
  wire        exec_ok_w = step_w && (state_reg == psc_pkg::PSC_EXEC) && for_me_w && (status_reg == psc_pkg::ST_OK);
  wire        glob_wr_w = exec_ok_w && (op_w == psc_pkg::OP_WRITE_GLOBAL) && bank_ok(bank_w);
  wire        nv_load_w = step_w && nv_done && nv_req_reg && !nv_write_reg;
  wire        exec_nv_w = (status_reg == psc_pkg::ST_OK) && needs_nv(op_w, bank_w);

  // Reply byte select, value MSB first as in the command frame
  logic [7:0] reply_sel;
  always_comb begin
    unique case (cnt_reg)
      4'h0: reply_sel = psc_pkg::REPLY_ADDR;
      4'h1: reply_sel = module_addr;
      4'h2: reply_sel = status_reg;
      4'h3: reply_sel = op_w;
      4'h4: reply_sel = rval_reg[31:24];
      4'h5: reply_sel = rval_reg[23:16];
      4'h6: reply_sel = rval_reg[15:8];
      4'h7: reply_sel = rval_reg[7:0];
      default: reply_sel = sum_reg;
    endcase
  end

  // tx_valid and ready drop while frozen, so no byte is offered or taken twice
  assign tx_valid    = step_w && (state_reg == psc_pkg::PSC_REPLY) && reply_now_reg;
  assign tx_byte     = tx_byte_reg;
  assign nv_req      = nv_req_reg;
  assign nv_write    = nv_write_reg;
  assign nv_global   = nv_global_reg;
  assign nv_bank     = nv_bank_reg;
  assign nv_index    = nv_index_reg;
  assign nv_wdata    = nv_wdata_reg;
  assign accumulator = acc_reg;
  assign ready       = step_w && ((state_reg == psc_pkg::PSC_IDLE) || (state_reg == psc_pkg::PSC_RECV));

  // Parameter RAMs have no reset; the boot reload fills the axis table and, with user_auto_restore, the user bank
  always_ff @(posedge core_clk) begin
    if (nv_load_w) begin
      if (nv_global_reg) begin
        glob_mem[nv_bank_reg[1:0]][nv_index_reg] <= nv_rdata;
      end else begin
        axis_mem[nv_index_reg] <= nv_rdata;
      end
    end else if (glob_wr_w) begin
      // A bad checksum or a refused bank leaves the RAM untouched
      glob_mem[bidx_w][type_w] <= value_w;
    end
  end

  // Command sequencer: boot reload, then one frame and one reply at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg     <= psc_pkg::PSC_BOOT;
      cnt_reg       <= 4'h0;
      sum_reg       <= 8'h00;
      status_reg    <= psc_pkg::ST_OK;
      rval_reg      <= psc_pkg::ZERO_WORD;
      acc_reg       <= psc_pkg::ZERO_WORD;
      boot_user_reg <= 1'b0;
      boot_glob_reg <= 1'b0;
      boot_idx_reg  <= 8'h00;
      nv_req_reg    <= 1'b0;
      nv_write_reg  <= 1'b0;
      nv_global_reg <= 1'b0;
      nv_bank_reg   <= 8'h00;
      nv_index_reg  <= 8'h00;
      nv_wdata_reg  <= psc_pkg::ZERO_WORD;
      reply_now_reg <= 1'b0;
      tx_byte_reg   <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        frame_reg[i] <= 8'h00;
      end
    end else if (step_w) begin
      unique case (state_reg)
        psc_pkg::PSC_BOOT: begin
          // Axis table first, then user variables if configured
          if (!nv_req_reg) begin
            nv_req_reg    <= 1'b1;
            nv_write_reg  <= 1'b0;
            nv_global_reg <= boot_glob_reg;
            nv_bank_reg   <= boot_glob_reg ? psc_pkg::BANK_USER : psc_pkg::BANK_SETTINGS;
            nv_index_reg  <= boot_idx_reg;
            if (!boot_user_reg) begin
              boot_user_reg <= 1'b1;
              boot_glob_reg <= 1'b0;
            end
          end else if (nv_done) begin
            nv_req_reg   <= 1'b0;
            boot_idx_reg <= boot_idx_reg + 8'h01;
            if (boot_idx_reg == psc_pkg::PARAM_LAST) begin
              if (!nv_global_reg && user_auto_restore) begin
                boot_glob_reg <= 1'b1;
              end else begin
                state_reg <= psc_pkg::PSC_IDLE;
              end
            end
          end
        end
        psc_pkg::PSC_IDLE, psc_pkg::PSC_RECV: begin
          if (rx_take) begin
            sum_reg <= sum_next;
            if (cnt_reg == psc_pkg::FRAME_LAST) begin
              cnt_reg   <= 4'h0;
              status_reg <= sum_ok_w ? psc_pkg::ST_OK : psc_pkg::ST_BAD_SUM;
              state_reg <= psc_pkg::PSC_EXEC;
            end else begin
              frame_reg[cnt_reg[2:0]] <= rx_byte;
              cnt_reg   <= cnt_reg + 4'h1;
              state_reg <= psc_pkg::PSC_RECV;
            end
          end
        end
        psc_pkg::PSC_EXEC: begin
          rval_reg <= psc_pkg::ZERO_WORD;
          state_reg <= psc_pkg::PSC_REPLY;
          // Wrong address: drop silently, no reply on a shared bus
          if (!for_me_w) begin
            state_reg <= psc_pkg::PSC_IDLE;
          end else if (status_reg == psc_pkg::ST_OK) begin
            // Refused banks answer with status 4 and change nothing
            unique case (op_w)
              psc_pkg::OP_SAVE_AXIS, psc_pkg::OP_RELOAD_AXIS: begin
                nv_req_reg    <= 1'b1;
                nv_write_reg  <= (op_w == psc_pkg::OP_SAVE_AXIS);
                nv_global_reg <= 1'b0;
                nv_bank_reg   <= bank_w;
                nv_index_reg  <= type_w;
                nv_wdata_reg  <= axis_mem[type_w];
                state_reg     <= psc_pkg::PSC_NVWAIT;
              end
              psc_pkg::OP_WRITE_GLOBAL: begin
                if (!bank_ok(bank_w)) begin
                  status_reg <= psc_pkg::ST_BAD_VALUE;
                end else if (bank_w == psc_pkg::BANK_SETTINGS) begin
                  nv_req_reg    <= 1'b1;
                  nv_write_reg  <= 1'b1;
                  nv_global_reg <= 1'b1;
                  nv_bank_reg   <= bank_w;
                  nv_index_reg  <= type_w;
                  nv_wdata_reg  <= value_w;
                  state_reg     <= psc_pkg::PSC_NVWAIT;
                end
              end
              psc_pkg::OP_READ_GLOBAL: begin
                if (!bank_ok(bank_w)) begin
                  status_reg <= psc_pkg::ST_BAD_VALUE;
                end else begin
                  rval_reg <= glob_rd_w;
                  if (standalone_mode) begin
                    acc_reg <= glob_rd_w;
                  end
                end
              end
              psc_pkg::OP_SAVE_GLOBAL: begin
                if (bank_w != psc_pkg::BANK_USER) begin
                  status_reg <= psc_pkg::ST_BAD_VALUE;
                end else begin
                  nv_req_reg    <= 1'b1;
                  nv_write_reg  <= 1'b1;
                  nv_global_reg <= 1'b1;
                  nv_bank_reg   <= bank_w;
                  nv_index_reg  <= type_w;
                  nv_wdata_reg  <= glob_rd_w;
                  state_reg     <= psc_pkg::PSC_NVWAIT;
                end
              end
              default: status_reg <= psc_pkg::ST_BAD_CMD;
            endcase
          end
          // Standalone sends no reply, but NV work still runs through the wait state
          if (for_me_w && standalone_mode && !exec_nv_w) begin
            state_reg <= psc_pkg::PSC_IDLE;
          end
        end
        psc_pkg::PSC_NVWAIT: begin
          // Request stands until done; a load lands in the RAM process
          if (nv_done) begin
            nv_req_reg <= 1'b0;
            state_reg  <= standalone_mode ? psc_pkg::PSC_IDLE : psc_pkg::PSC_REPLY;
          end
        end
        psc_pkg::PSC_REPLY: begin
          // Byte loaded one cycle, offered the next; the sink may stall
          if (!reply_now_reg) begin
            tx_byte_reg   <= reply_sel;
            sum_reg       <= sum_step(cnt_reg, sum_reg, reply_sel);
            reply_now_reg <= 1'b1;
          end else if (tx_take) begin
            reply_now_reg <= 1'b0;
            if (cnt_reg == psc_pkg::REPLY_LAST) begin
              cnt_reg   <= 4'h0;
              state_reg <= psc_pkg::PSC_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        default: state_reg <= psc_pkg::PSC_IDLE;
      endcase
    end
  end
endmodule

/* psc_pkg.sv */
// Package for the parameter store command handler.
// Assumes a byte-wide frame input stream and a byte-wide reply stream.
package psc_pkg;
  localparam logic [7:0]  OP_SAVE_AXIS    = 8'h07;
  localparam logic [7:0]  OP_RELOAD_AXIS  = 8'h08;
  localparam logic [7:0]  OP_WRITE_GLOBAL = 8'h09;
  localparam logic [7:0]  OP_READ_GLOBAL  = 8'h0A;
  localparam logic [7:0]  OP_SAVE_GLOBAL  = 8'h0B;
  localparam logic [7:0]  BANK_SETTINGS   = 8'h00;
  localparam logic [7:0]  BANK_USER       = 8'h02;
  localparam logic [7:0]  BANK_IRQ        = 8'h03;
  localparam logic [7:0]  ST_OK           = 8'h64;
  localparam logic [7:0]  ST_BAD_SUM      = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD      = 8'h02;
  localparam logic [7:0]  ST_BAD_VALUE    = 8'h04;
  localparam logic [7:0]  REPLY_ADDR      = 8'h02;
  localparam logic [3:0]  FRAME_LAST      = 4'h8;
  localparam logic [3:0]  REPLY_LAST      = 4'h8;
  localparam logic [7:0]  PARAM_LAST      = 8'hFF;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
  typedef enum {PSC_IDLE, PSC_BOOT, PSC_RECV, PSC_EXEC, PSC_NVWAIT, PSC_REPLY} psc_state_t;
  typedef enum {PSC_NV_NONE, PSC_NV_AXIS, PSC_NV_GLOBAL} psc_nv_sel_t;
endpackage

/* psc_core_sva.sv */
// Checker for the parameter store handler ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ns
module psc_core_sva (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        standalone_mode,
  input wire logic        ready,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        nv_req,
  input wire logic        nv_write,
  input wire logic        nv_done,
  input wire logic [7:0]  tx_byte,
  input wire logic [7:0]  nv_bank,
  input wire logic [7:0]  nv_index,
  input wire logic [31:0] nv_wdata,
  input wire logic [31:0] accumulator
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_req_hold; nv_req && !nv_done |=> nv_req && $stable({nv_write, nv_bank, nv_index, nv_wdata}); endproperty
  a_req_hold: assert property (p_req_hold) else $error("nv request changed before done");
  property p_req_drop; nv_done |=> !nv_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("nv request held after done");
  property p_boot; $fell(rst) && clk_en |-> ##[1:2] nv_req; endproperty
  a_boot: assert property (p_boot) else $error("no reload after reset");
  property p_reset; disable iff (1'b0) rst |=> !tx_valid && !nv_req && !ready && accumulator == 32'h0000_0000; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_tx_hold; tx_valid && !tx_ready |=> (tx_valid || !clk_en) && $stable(tx_byte); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte lost while stalled");
  property p_busy; tx_valid |-> !ready; endproperty
  a_busy: assert property (p_busy) else $error("frame accepted during reply");
  property p_acc_keep; !standalone_mode |=> $stable(accumulator); endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("accumulator changed in direct mode");
  property p_quiet; standalone_mode |-> !tx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("reply sent in standalone mode");
endmodule

/* psc_host_model.sv */
// Host model: sends command frames and collects replies.
// Assumes the handler's clock and a reply sink that may stall.
`timescale 1ns/1ns
module psc_host_model (
  input  wire logic       core_clk,
  input  wire logic       ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_ready
);
  logic       stall = 1'b0;
  logic [7:0] rep [9];
  int         n_rep = 0;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b1;
  end
  // Toggling sink forces held reply bytes
  always @(posedge core_clk) tx_ready <= stall ? ~tx_ready : 1'b1;
  always @(negedge core_clk) if (tx_valid && tx_ready && n_rep < 9) begin
    rep[n_rep] = tx_byte;
    n_rep++;
  end
  task automatic send(input logic [7:0] a, op, typ, bank, input logic [31:0] v, input logic [7:0] bad);
    logic [7:0] f [9];
    f = '{a, op, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int k = 0; k < 8; k++) f[8] += f[k];
    f[8] ^= bad;
    n_rep = 0;
    while (ready !== 1'b1) @(posedge core_clk);
    for (int k = 0; k < 9; k++) begin
      rx_valid <= 1'b1;
      rx_byte  <= f[k];
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    rx_byte  <= ~f[8];
  endtask
endmodule

/* parameter_store_commands_tb.sv */
// Testbench for the parameter store handler with host and NV memory models.
// Assumes frames are answered only after the boot reload completes.
`timescale 1ns/1ns
module parameter_store_commands_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        standalone_mode = 1'b0;
  logic        user_auto_restore = 1'b1;
  logic        rx_valid, tx_valid, tx_ready, nv_req, nv_write, nv_global, ready;
  logic        nv_done = 1'b0;
  logic        nv_busy = 1'b0;
  logic        nv_slow = 1'b0;
  logic [2:0]  nv_cnt = 3'h0;
  logic [7:0]  rx_byte, tx_byte, nv_bank, nv_index;
  logic [31:0] nv_wdata, accumulator;
  logic [31:0] nv_rdata = 32'h0000_0000;
  logic [31:0] nv_axis [256];
  logic [31:0] nv_glob [4][256];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          n_axis_ld = 0;
  int          n_glob_ld = 0;
  psc_core dut (.core_clk, .rst, .clk_en(1'b1), .standalone_mode, .user_auto_restore, .module_addr(8'h01),
    .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .nv_req, .nv_write, .nv_global, .nv_bank,
    .nv_index, .nv_wdata, .nv_done, .nv_rdata, .accumulator, .ready);
  psc_host_model host (.core_clk, .ready, .tx_valid, .tx_byte, .rx_valid, .rx_byte, .tx_ready);
  initial forever #10 core_clk = ~core_clk;
  initial for (int i = 0; i < 256; i++) begin
    nv_axis[i] = 32'hA500_0000 + i;
    for (int b = 0; b < 4; b++) nv_glob[b][i] = 32'h5A00_0000 + i;
  end
  // NV memory; read data scrambles between answers
  always @(posedge core_clk) begin
    nv_done  <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (nv_req && !nv_done && !nv_busy) begin
      nv_busy <= 1'b1;
      nv_cnt  <= nv_slow ? 3'h5 : 3'h0;
    end else if (nv_busy && nv_cnt != 3'h0) nv_cnt <= nv_cnt - 3'h1;
    else if (nv_busy) begin
      nv_busy <= 1'b0;
      nv_done <= 1'b1;
      if (nv_write && nv_global) nv_glob[nv_bank[1:0]][nv_index] <= nv_wdata;
      else if (nv_write) nv_axis[nv_index] <= nv_wdata;
      else if (nv_global) begin
        nv_rdata <= nv_glob[nv_bank[1:0]][nv_index];
        n_glob_ld++;
      end else begin
        nv_rdata <= nv_axis[nv_index];
        n_axis_ld++;
      end
    end
  end
  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, typ, bank, input logic [31:0] v, input logic [7:0] bad, st,
                     input logic [31:0] rv, input logic vc);
    logic [7:0] e [9];
    host.send(8'h01, op, typ, bank, v, bad);
    e = '{psc_pkg::REPLY_ADDR, 8'h01, st, op, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
    for (int k = 0; k < 8; k++) e[8] += e[k];
    for (int w = 0; w < 300 && host.n_rep < 9; w++) @(posedge core_clk);
    check(host.n_rep, 9);
    for (int k = 0; k < 9; k++) if (vc || k < 4) check(host.rep[k], e[k]);
  endtask
  task automatic t_boot;
    for (int w = 0; w < 6000 && ready !== 1'b1; w++) @(posedge core_clk);
    check(n_axis_ld, 256);
    check(n_glob_ld, 256);
    $display("boot reload done");
  endtask
  task automatic t_global;
    logic [7:0] b [3] = '{8'h00, 8'h02, 8'h03};
    for (int i = 0; i < 3; i++) begin
      cmd(8'h09, 8'h11, b[i], 32'h1234_5600 + i, 8'h00, psc_pkg::ST_OK, 32'h0, 1'b0);
      cmd(8'h0A, 8'h11, b[i], 32'hFFFF_FFFF, 8'h00, psc_pkg::ST_OK, 32'h1234_5600 + i, 1'b1);
    end
    check(accumulator, 32'h0000_0000);
    check(nv_glob[0][8'h11], 32'h1234_5600);
    check(nv_glob[2][8'h11], 32'h5A00_0011);
    cmd(8'h09, 8'h11, 8'h01, 32'h0, 8'h00, psc_pkg::ST_BAD_VALUE, 32'h0, 1'b0);
    cmd(8'h0B, 8'h11, 8'h00, 32'h0, 8'h00, psc_pkg::ST_BAD_VALUE, 32'h0, 1'b0);
    cmd(8'h09, 8'h11, 8'h02, 32'hDEAD_0000, 8'h40, psc_pkg::ST_BAD_SUM, 32'h0, 1'b0);
    $display("global write, read and refusals done");
  endtask
  task automatic t_save;
    nv_slow <= 1'b1;
    host.stall <= 1'b1;
    @(posedge core_clk);
    cmd(8'h0B, 8'h11, 8'h02, 32'h0, 8'h00, psc_pkg::ST_OK, 32'h0, 1'b0);
    check(nv_glob[2][8'h11], 32'h1234_5601);
    nv_axis[6] = 32'h0;
    cmd(8'h07, 8'h06, 8'h00, 32'h0, 8'h00, psc_pkg::ST_OK, 32'h0, 1'b0);
    check(nv_axis[6], 32'hA500_0006);
    nv_axis[6] = 32'hC0DE_0006;
    cmd(8'h08, 8'h06, 8'h00, 32'h0, 8'h00, psc_pkg::ST_OK, 32'h0, 1'b0);
    nv_axis[6] = 32'h0;
    cmd(8'h07, 8'h06, 8'h00, 32'h0, 8'h00, psc_pkg::ST_OK, 32'h0, 1'b0);
    check(nv_axis[6], 32'hC0DE_0006);
    $display("save and reload done");
  endtask
  task automatic t_standalone;
    standalone_mode <= 1'b1;
    @(posedge core_clk);
    host.send(8'h01, 8'h0A, 8'h11, 8'h02, 32'h0, 8'h00);
    repeat (40) @(posedge core_clk);
    check(accumulator, 32'h1234_5601);
    check(host.n_rep, 0);
    host.send(8'h01, 8'h09, 8'h22, 8'h00, 32'h0BAD_CAFE, 8'h00);
    repeat (40) @(posedge core_clk);
    check(nv_glob[0][8'h22], 32'h0BAD_CAFE);
    check(host.n_rep, 0);
    standalone_mode <= 1'b0;
    $display("standalone read done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_boot;
    t_global;
    t_save;
    t_standalone;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    complete_run;
  end
endmodule
bind psc_core psc_core_sva u_sva (.core_clk, .rst, .clk_en, .standalone_mode, .ready, .tx_valid, .tx_ready,
  .nv_req, .nv_write, .nv_done, .tx_byte, .nv_bank, .nv_index, .nv_wdata, .accumulator);
